//--- hdl/dlseq_map.vh
`ifndef DLSEQ_MAP_VH
`define DLSEQ_MAP_VH

// ---------------------------------------------------------------
// timebase
// ---------------------------------------------------------------
`define DLSEQ_CLK_HZ        100000000
`define DLSEQ_TICK_MS       1
`define DLSEQ_TICK_CYC      ((`DLSEQ_CLK_HZ / 1000) * `DLSEQ_TICK_MS)

// ---------------------------------------------------------------
// sequence times in milliseconds
// ---------------------------------------------------------------
`define DLSEQ_PULSE_MS      20
`define DLSEQ_GAP_MS        200
`define DLSEQ_POWERUP_MS    6000
`define DLSEQ_LOCK_TMO_MS   20000

// ---------------------------------------------------------------
// release limits
// ---------------------------------------------------------------
`define DLSEQ_TEMP_MAX_C    40
`define DLSEQ_TEMP_W        8
`define DLSEQ_LEVEL_W       8

`endif

//--- hdl/dlseq_ms_timer.v
`timescale 1ns/100ps
`include "dlseq_map.vh"

// millisecond down-counter, loaded with a duration, flags done
module dlseq_ms_timer #(
	parameter CNT_W = 16
) (
	// clock and reset
	input  wire             clk,
	input  wire             rst,
	// millisecond tick
	input  wire             tick,
	// control
	input  wire             load,
	input  wire [CNT_W-1:0] load_ms,
	// status
	output reg              done
);

	reg [CNT_W-1:0] cnt_r;

	always @(posedge clk) begin
		if (rst) begin
			cnt_r <= {CNT_W{1'b0}};
			done  <= 1'b1;
		end else if (load) begin
			cnt_r <= load_ms;
			done  <= 1'b0;
		end else if (tick && !done) begin
			if (cnt_r <= {{(CNT_W-1){1'b0}}, 1'b1}) begin
				cnt_r <= {CNT_W{1'b0}};
				done  <= 1'b1;
			end else begin
				cnt_r <= cnt_r - {{(CNT_W-1){1'b0}}, 1'b1};
			end
		end
	end

endmodule

//--- hdl/dlseq_top.v
`timescale 1ns/100ps
`include "dlseq_map.vh"

// Overview of operation
// - one 20 ms lock pulse at start
// - no lock pulse before 6 s powered
// - main switch closed after lock pulse
// - two 20 ms release pulses, 200 ms apart
// - first release pulse keeps door locked
// - second pulse unlocks, opens main switch
// - release needs drum stationary
// - release needs level at or below door edge
// - release needs temperature at most 40 C
// - lock not achieved in 20 s raises alarm
module dlseq_top #(
	parameter TICK_CYC   = `DLSEQ_TICK_CYC,
	parameter POWERUP_MS = `DLSEQ_POWERUP_MS,
	parameter LOCK_TMO_MS = `DLSEQ_LOCK_TMO_MS,
	parameter [`DLSEQ_LEVEL_W-1:0] DOOR_EDGE_LVL = 8'h40
) (
	// clock and reset
	input  wire                       CLK,
	input  wire                       RST,
	// user requests
	input  wire                       START_PAUSE,
	input  wire                       PROG_END,
	input  wire                       ALARM_CLR,
	// sensors
	input  wire                       DRUM_MOVING,
	input  wire [`DLSEQ_LEVEL_W-1:0]  WATER_LEVEL,
	input  wire [`DLSEQ_TEMP_W-1:0]   WATER_TEMP,
	input  wire                       LOCK_SENSE,
	// solenoid and status
	output reg                        SOL_PULSE,
	output reg                        MAIN_SW_CLOSED,
	output reg                        DOOR_LOCKED,
	output reg                        RELEASE_PENDING,
	output reg                        DOOR_ALARM,
	output reg                        CYCLE_PAUSE
);

	// ---------------------------------------------------------------
	// states
	// ---------------------------------------------------------------
	localparam [6:0] S_IDLE  = 7'h01;
	localparam [6:0] S_WPWR  = 7'h02;
	localparam [6:0] S_LPUL  = 7'h04;
	localparam [6:0] S_LOCK  = 7'h08;
	localparam [6:0] S_RPUL1 = 7'h10;
	localparam [6:0] S_RGAP  = 7'h20;
	localparam [6:0] S_RPUL2 = 7'h40;

	localparam [15:0] PULSE_MS = `DLSEQ_PULSE_MS;
	localparam [15:0] GAP_MS   = `DLSEQ_GAP_MS;
	localparam [`DLSEQ_TEMP_W-1:0] TEMP_MAX = `DLSEQ_TEMP_MAX_C;

	reg  [6:0]  state_r;
	reg  [6:0]  state_nxt;
	reg  [31:0] div_r;
	reg         tick_r;
	reg  [15:0] pwr_ms_r;
	reg         pwr_ok_r;
	reg  [15:0] tmo_ms_r;
	reg         tmo_run_r;
	reg         sp_d_r;
	reg         rel_req_r;
	reg         tmr_load;
	reg  [15:0] tmr_ms;
	wire        tmr_done;
	wire        sp_edge;
	wire        rel_ok;

	assign sp_edge = START_PAUSE && !sp_d_r;

	assign rel_ok = !DRUM_MOVING && (WATER_LEVEL <= DOOR_EDGE_LVL) && (WATER_TEMP <= TEMP_MAX);

	// ---------------------------------------------------------------
	// millisecond timebase
	// ---------------------------------------------------------------
	// tick and power-up count
	always @(posedge CLK) begin
		if (RST) begin
			div_r    <= 32'h00000000;
			tick_r   <= 1'b0;
			pwr_ms_r <= 16'h0000;
			pwr_ok_r <= 1'b0;
		end else begin
			tick_r <= 1'b0;
			if (div_r >= TICK_CYC - 1) begin
				div_r  <= 32'h00000000;
				tick_r <= 1'b1;
			end else begin
				div_r <= div_r + 32'h00000001;
			end
			if (tick_r && !pwr_ok_r) begin
				if (pwr_ms_r >= POWERUP_MS - 1)
					pwr_ok_r <= 1'b1;
				else
					pwr_ms_r <= pwr_ms_r + 16'h0001;
			end
		end
	end

	dlseq_ms_timer #(
		.CNT_W   (16)
	) u_tmr (
		.clk     (CLK),
		.rst     (RST),
		.tick    (tick_r),
		.load    (tmr_load),
		.load_ms (tmr_ms),
		.done    (tmr_done)
	);

	// ---------------------------------------------------------------
	// sequencer
	// ---------------------------------------------------------------
	always @* begin
		state_nxt = state_r;
		tmr_load  = 1'b0;
		tmr_ms    = PULSE_MS;
		case (state_r)
			S_IDLE: begin
				if (sp_edge && !DOOR_ALARM)
					state_nxt = S_WPWR;
			end
			S_WPWR: begin
				if (pwr_ok_r) begin
					state_nxt = S_LPUL;
					tmr_load  = 1'b1;
				end
			end
			S_LPUL: begin
				if (tmr_done && !tmr_load)
					state_nxt = S_LOCK;
			end
			S_LOCK: begin
				if (rel_req_r && rel_ok) begin
					state_nxt = S_RPUL1;
					tmr_load  = 1'b1;
				end
			end
			S_RPUL1: begin
				if (tmr_done) begin
					state_nxt = S_RGAP;
					tmr_load  = 1'b1;
					tmr_ms    = GAP_MS - PULSE_MS;
				end
			end
			S_RGAP: begin
				// second pulse only if still all clear
				if (tmr_done && rel_ok) begin
					state_nxt = S_RPUL2;
					tmr_load  = 1'b1;
				end
			end
			S_RPUL2: begin
				if (tmr_done)
					state_nxt = S_IDLE;
			end
			default: state_nxt = S_IDLE;
		endcase
	end

	always @(posedge CLK) begin
		if (RST) begin
			state_r         <= S_IDLE;
			sp_d_r          <= 1'b0;
			rel_req_r       <= 1'b0;
			tmo_ms_r        <= 16'h0000;
			tmo_run_r       <= 1'b0;
			SOL_PULSE       <= 1'b0;
			MAIN_SW_CLOSED  <= 1'b0;
			DOOR_LOCKED     <= 1'b0;
			RELEASE_PENDING <= 1'b0;
			DOOR_ALARM      <= 1'b0;
			CYCLE_PAUSE     <= 1'b0;
		end else begin
			state_r <= state_nxt;
			sp_d_r  <= START_PAUSE;
			// end or pause while locked requests release
			if (state_r == S_LOCK && (PROG_END || sp_edge))
				rel_req_r <= 1'b1;
			else if (state_nxt == S_RPUL1)
				rel_req_r <= 1'b0;
			RELEASE_PENDING <= (state_nxt == S_LOCK) &&
				(rel_req_r || (state_r == S_LOCK && (PROG_END || sp_edge)));
			SOL_PULSE <= (state_nxt == S_LPUL) || (state_nxt == S_RPUL1) ||
				(state_nxt == S_RPUL2);
			// lock and switch change at the end of the lock pulse and of the second release pulse
			if (state_r == S_LPUL && state_nxt == S_LOCK) begin
				MAIN_SW_CLOSED <= 1'b1;
				DOOR_LOCKED    <= 1'b1;
			end else if (state_r == S_RPUL2 && state_nxt == S_IDLE) begin
				MAIN_SW_CLOSED <= 1'b0;
				DOOR_LOCKED    <= 1'b0;
			end
			if (state_r == S_IDLE && state_nxt == S_WPWR) begin
				tmo_run_r <= 1'b1;
				tmo_ms_r  <= 16'h0000;
			end else if (LOCK_SENSE || state_r == S_IDLE) begin
				tmo_run_r <= 1'b0;
			end else if (tmo_run_r && tick_r) begin
				if (tmo_ms_r >= LOCK_TMO_MS - 1) begin
					tmo_run_r   <= 1'b0;
					DOOR_ALARM  <= 1'b1;
					CYCLE_PAUSE <= 1'b1;
				end else begin
					tmo_ms_r <= tmo_ms_r + 16'h0001;
				end
			end
			// alarm set wins over clear
			if (ALARM_CLR && !(tmo_run_r && tick_r && tmo_ms_r >= LOCK_TMO_MS - 1)) begin
				DOOR_ALARM  <= 1'b0;
				CYCLE_PAUSE <= 1'b0;
			end
		end
	end

endmodule

//--- testbench/dlseq_chk.sv
`timescale 1ns/100ps
module dlseq_chk #(
	parameter       TICK_CYC      = 10,
	parameter       POWERUP_MS    = 5,
	parameter [7:0] DOOR_EDGE_LVL = 8'h40
) (
	// clock and reset
	input wire       CLK,
	input wire       RST,
	// sensors
	input wire       DRUM_MOVING,
	input wire [7:0] WATER_LEVEL,
	input wire [7:0] WATER_TEMP,
	input wire       LOCK_SENSE,
	// outputs
	input wire       SOL_PULSE,
	input wire       MAIN_SW_CLOSED,
	input wire       DOOR_LOCKED,
	input wire       RELEASE_PENDING,
	input wire       DOOR_ALARM,
	input wire       CYCLE_PAUSE
);
	// ----------------------------------------
	// cycle counters
	// ----------------------------------------
	int  hi_r;
	int  lo_r;
	int  up_r;
	// release pulses seen while locked, to single out the second one
	int  np_r;
	reg  sol_d_r;
	wire ok_w = !DRUM_MOVING && WATER_LEVEL <= DOOR_EDGE_LVL && WATER_TEMP <= 8'h28;
	always @(posedge CLK) begin
		hi_r <= RST ? 0 : (SOL_PULSE ? hi_r + 1 : 0);
		lo_r <= RST ? 0 : (SOL_PULSE ? 0 : lo_r + 1);
		up_r <= RST ? 0 : up_r + 1;
		sol_d_r <= RST ? 1'b0 : SOL_PULSE;
		np_r <= (RST || !DOOR_LOCKED) ? 0 : np_r + ((SOL_PULSE && !sol_d_r) ? 1 : 0);
	end
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);
	sequence pulse_end_s; $fell(SOL_PULSE); endsequence
	sequence rel_rise_s; DOOR_LOCKED && $rose(SOL_PULSE); endsequence
	sequence rel2_rise_s; DOOR_LOCKED && $rose(SOL_PULSE) && np_r == 1; endsequence
	// ----------------------------------------
	// properties
	// ----------------------------------------
	a_pulse_width: assert property (pulse_end_s |-> hi_r >= 19*TICK_CYC && hi_r <= 21*TICK_CYC)
		else $error("solenoid pulse width out of range");
	a_powerup_wait: assert property ($rose(SOL_PULSE) |-> up_r >= (POWERUP_MS-1)*TICK_CYC)
		else $error("pulse before power-up delay");
	a_lock_closes: assert property (pulse_end_s ##0 !$past(DOOR_LOCKED) |-> ##[0:2] MAIN_SW_CLOSED)
		else $error("switch not closed after lock pulse");
	a_switch_lock: assert property (MAIN_SW_CLOSED == DOOR_LOCKED)
		else $error("switch and lock disagree");
	a_gap_spacing: assert property (rel2_rise_s |-> lo_r >= 179*TICK_CYC)
		else $error("release pulse gap too short");
	a_release_gated: assert property (rel_rise_s |-> $past(ok_w))
		else $error("release pulse with conditions unmet");
	a_unlock_at_pulse: assert property ($fell(DOOR_LOCKED) |-> lo_r <= 3)
		else $error("unlock away from pulse end");
	a_pending_holds: assert property (RELEASE_PENDING && !ok_w |=> !$rose(SOL_PULSE) && DOOR_LOCKED)
		else $error("pending release not held");
	a_alarm_pause: assert property ($rose(DOOR_ALARM) |-> CYCLE_PAUSE && !$past(LOCK_SENSE))
		else $error("alarm without pause or with lock");
endmodule
bind dlseq_top dlseq_chk #(.TICK_CYC(TICK_CYC), .POWERUP_MS(POWERUP_MS),
	.DOOR_EDGE_LVL(DOOR_EDGE_LVL)) chk_u (.*);

//--- testbench/dlseq_cam_model.sv
`timescale 1ns/100ps
module dlseq_cam_model (
	// solenoid side
	input  wire clk,
	input  wire rst,
	input  wire sol,
	// stuck pin and sense
	input  wire jam,
	output wire lock_sense
);
	reg [1:0] pos_r;
	reg       sol_r;
	// ----------------------------------------
	// cam stepping
	// ----------------------------------------
	// lock, hold, then unlock
	always @(posedge clk) begin
		sol_r <= sol;
		if (rst) begin
			pos_r <= 2'h0;
		end else if (sol && !sol_r) begin
			pos_r <= (pos_r == 2'h2) ? 2'h0 : pos_r + 2'h1;
		end
	end
	// a stuck pin never reports the lock
	assign lock_sense = !jam && pos_r != 2'h0;
endmodule

//--- testbench/dlseq_top_test.sv
`timescale 1ns/100ps
module dlseq_top_test;
	reg       clk = 1'b0;
	reg       rst = 1'b1;
	reg       sp  = 1'b0;
	reg       pe  = 1'b0;
	reg       dm  = 1'b0;
	reg       jam = 1'b0;
	reg       clr = 1'b0;
	reg [7:0] lvl = 8'h10;
	reg [7:0] tmp = 8'h14;
	wire      ls, sol, msw, lck, pend, alm, pau;
	int       error_cnt = 0;
	int       n_checks = 0;
	// ----------------------------------------
	// design and cam
	// ----------------------------------------
	dlseq_top #(.TICK_CYC(10), .POWERUP_MS(5), .LOCK_TMO_MS(50)) dut_u (.CLK(clk), .RST(rst),
		.START_PAUSE(sp), .PROG_END(pe), .ALARM_CLR(clr), .DRUM_MOVING(dm), .WATER_LEVEL(lvl),
		.WATER_TEMP(tmp), .LOCK_SENSE(ls), .SOL_PULSE(sol), .MAIN_SW_CLOSED(msw),
		.DOOR_LOCKED(lck), .RELEASE_PENDING(pend), .DOOR_ALARM(alm), .CYCLE_PAUSE(pau));
	dlseq_cam_model cam_u (.clk(clk), .rst(rst), .sol(sol), .jam(jam), .lock_sense(ls));
	initial forever #5 clk = ~clk;
	task give_verdict;
		if (error_cnt == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task chk(input string n, input logic [7:0] e, input logic [7:0] s);
		n_checks++;
		if (s !== e) begin
			$display("MISMATCH %s expected %h seen %h", n, e, s);
			error_cnt++;
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task wsol(input logic v, input int lim, output int t);
		for (t = 0; t < lim && sol !== v; t++) cyc(1);
		chk("sol", {7'h00, v}, {7'h00, sol});
	endtask
	// start right at reset release
	task t_lock;
		int t;
		sp = 1'b1;
		wsol(1'b1, 200, t);
		chk("powerup", 8'h01, {7'h00, t >= 40});
		sp = 1'b0;
		wsol(1'b0, 260, t);
		chk("lock_width", 8'h01, {7'h00, t >= 185 && t <= 210});
		cyc(3);
		chk("locked", 8'h03, {6'h00, lck, msw});
	endtask
	// each condition just past its limit, then all at the limit
	task t_release;
		int t;
		int i;
		pe = 1'b1;
		for (i = 0; i < 3; i++) begin
			dm = (i == 0);
			lvl = (i == 1) ? 8'h41 : 8'h40;
			tmp = (i == 2) ? 8'h29 : 8'h28;
			cyc(300);
			chk("pending", 8'h02, {6'h00, pend, sol});
		end
		dm = 1'b0;
		tmp = 8'h28;
		wsol(1'b1, 30, t);
		wsol(1'b0, 260, t);
		cyc(100);
		chk("first", 8'h03, {6'h00, lck, msw});
		wsol(1'b1, 2000, t);
		chk("gap", 8'h01, {7'h00, t >= 1680 && t <= 1720});
		wsol(1'b0, 260, t);
		cyc(3);
		chk("unlock", 8'h00, {6'h00, lck, msw});
		pe = 1'b0;
	endtask
	// stuck pin: lock never sensed
	task t_alarm;
		int t;
		jam = 1'b1;
		sp = 1'b1;
		cyc(2);
		sp = 1'b0;
		for (t = 0; t < 700 && alm !== 1'b1; t++) cyc(1);
		chk("timeout", 8'h01, {7'h00, t >= 485 && t <= 520});
		chk("paused", 8'h03, {6'h00, alm, pau});
		clr = 1'b1;
		cyc(1);
		clr = 1'b0;
		chk("alarm_clr", 8'h00, {6'h00, alm, pau});
		// pause press while locked releases the door
		sp = 1'b1;
		wsol(1'b1, 30, t);
		chk("sp_release", 8'h01, {7'h00, t <= 3});
		sp = 1'b0;
		wsol(1'b0, 260, t);
		wsol(1'b1, 2000, t);
		wsol(1'b0, 260, t);
		cyc(3);
		chk("sp_unlock", 8'h00, {6'h00, lck, msw});
	endtask
	initial begin
		repeat (12) @(posedge clk);
		#1;
		rst = 1'b0;
		t_lock;
		cyc(50);
		t_release;
		cyc(50);
		t_alarm;
		give_verdict;
	end
	// run needs about 6200 cycles
	initial begin
		#200000;
		error_cnt++;
		give_verdict;
	end
endmodule
